// *** hdl/acs_map.vh ***
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_CLK_PERIOD_NS    10
`define ACS_PART_MIN_NS      40
`define ACS_PART_MAX_NS      500
`define ACS_FULL_MIN_NS      1200
`define ACS_PART_MIN_CYC     ((`ACS_PART_MIN_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_PART_MAX_CYC     (`ACS_PART_MAX_NS / `ACS_CLK_PERIOD_NS)
`define ACS_FULL_MIN_CYC     ((`ACS_FULL_MIN_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_CONV_CYC         20
`define ACS_STEPS            32
`define ACS_PTR_W            5
`define ACS_SEL_W            4
`define ACS_STEP_W           9
`define ACS_FLD_ASEL_LSB     0
`define ACS_FLD_BSEL_LSB     4
`define ACS_FLD_END_BIT      8
`define ACS_STEP_RESET       9'h000
`endif

// *** hdl/acs_step_mem.v ***
`timescale 1ns/100ps
`default_nettype none
`include "acs_map.vh"
module acs_step_mem #(
  parameter DEPTH = `ACS_STEPS,
  parameter AW    = `ACS_PTR_W,
  parameter DW    = `ACS_STEP_W
) (
  input  wire          sys_clk,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  input  wire [AW-1:0] rdAddr,
  output reg  [DW-1:0] rdData
);
  reg [DW-1:0] stepMem [0:DEPTH-1];
  // contents survive every reset so a partial reset keeps the program
  always @(posedge sys_clk) begin
    if (wrEn) begin
      stepMem[wrAddr] <= wrData;
    end
    rdData <= stepMem[rdAddr];
  end
endmodule
`default_nettype wire

// *** hdl/acs_pulse_meter.v ***
`timescale 1ns/100ps
`default_nettype none
`include "acs_map.vh"
module acs_pulse_meter #(
  parameter CW = 8
) (
  input  wire sys_clk,
  input  wire sys_rst,
  input  wire pinRstN,
  output reg  partialPulse,
  output reg  fullPulse
);
  localparam integer  PART_MIN_I = `ACS_PART_MIN_CYC;
  localparam integer  PART_MAX_I = `ACS_PART_MAX_CYC;
  localparam integer  FULL_MIN_I = `ACS_FULL_MIN_CYC;
  localparam [CW-1:0] PART_MIN   = PART_MIN_I[CW-1:0];
  localparam [CW-1:0] PART_MAX   = PART_MAX_I[CW-1:0];
  localparam [CW-1:0] FULL_MIN   = FULL_MIN_I[CW-1:0];
  reg          syncA_reg;
  reg          syncB_reg;
  reg          lowPrev_reg;
  reg [CW-1:0] lowCnt_reg;
  wire         lowNow = ~syncB_reg;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // idle level of the pin, so no false low follows reset
      syncA_reg    <= 1'b1;
      syncB_reg    <= 1'b1;
      lowPrev_reg  <= 1'b0;
      lowCnt_reg   <= {CW{1'b0}};
      partialPulse <= 1'b0;
      fullPulse    <= 1'b0;
    end else begin
      syncA_reg    <= pinRstN;
      syncB_reg    <= syncA_reg;
      lowPrev_reg  <= lowNow;
      partialPulse <= 1'b0;
      fullPulse    <= 1'b0;
      if (lowNow) begin
        if (lowCnt_reg != FULL_MIN) begin
          lowCnt_reg <= lowCnt_reg + {{(CW-1){1'b0}}, 1'b1};
        end
      end else begin
        lowCnt_reg <= {CW{1'b0}};
        if (lowPrev_reg) begin
          // classify on the rising edge of the reset pin
          if (lowCnt_reg >= FULL_MIN) begin
            fullPulse <= 1'b1;
          end else if (lowCnt_reg >= PART_MIN && lowCnt_reg <= PART_MAX) begin
            partialPulse <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/acs_sequencer.v ***
// Contract
// - pin mode samples code during conversion
// - code at reset release picks first pair
// - three-bit code selects pair n
// - register mode takes pair from channel register
// - register mode resets selection to pair zero
// - register sequencer holds 32 free steps
// - one step per strobe, burst converts all
// - sequencer-enable pin latched at full reset
// - latched setting held until next full reset
// - pin sequencing converts matching pairs only
// - code k gives pairs 0 through k
// - code at reset sets first sequence length
// - step holds two four-bit selectors
// - sequence depth programmable 1 to 32
// - end marker step defines the depth
// - register sequencer runs when enable set
// - after last step wrap to first
// - partial reset rewinds pointer, keeps steps
// - config and steps writable by host
// - 40 to 500 ns low is partial
// - 1.2 us low is full reset
// - burst keeps busy high whole sequence
`timescale 1ns/100ps
`default_nettype none
`include "acs_map.vh"
module acs_sequencer #(
  parameter CONV_CYC = `ACS_CONV_CYC,
  parameter PW       = `ACS_PTR_W,
  parameter SW       = `ACS_SEL_W
) (
  input  wire          sys_clk,
  input  wire          sys_rst,
  input  wire          resetPinN,
  input  wire          regModePin,
  input  wire          sequencerEnablePin,
  input  wire          burstPin,
  input  wire [2:0]    channel_code_bus,
  input  wire          conversion_start_strobe,
  input  wire          cfgWrite,
  input  wire          cfgSeqEnable,
  input  wire          cfgBurst,
  input  wire [SW-1:0] cfgChanA,
  input  wire [SW-1:0] cfgChanB,
  input  wire          stepWrite,
  input  wire [PW-1:0] stepAddr,
  input  wire [SW-1:0] stepASel,
  input  wire [SW-1:0] stepBSel,
  input  wire          stepEnd,
  output reg           busy,
  output reg  [SW-1:0] a_side_selector,
  output reg  [SW-1:0] b_side_selector,
  output reg           convPulse,
  output reg  [PW-1:0] stepPointer,
  output reg           regModeActive,
  output reg           seqActive
);
  localparam [2:0] ST_IDLE = 3'b000;
  localparam [2:0] ST_LOAD = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_DONE = 3'b011;
  localparam [2:0] ST_NEXT = 3'b100;
  localparam integer CONV_LAST_I = CONV_CYC - 1;
  localparam [7:0]   CONV_LAST   = CONV_LAST_I[7:0];
  wire partialPulse;
  wire fullPulse;
  wire [`ACS_STEP_W-1:0] stepRd;
  reg  [2:0]    codeS1_reg;
  reg  [2:0]    codeS2_reg;
  reg           stS1_reg;
  reg           stS2_reg;
  reg           stPrev_reg;
  reg  [2:0]    rdyS1_reg;
  reg  [2:0]    rdyS2_reg;
  reg           regMode_reg;
  reg           hwSeq_reg;
  reg           hwBurst_reg;
  reg           swSeq_reg;
  reg           swBurst_reg;
  reg  [SW-1:0] chanA_reg;
  reg  [SW-1:0] chanB_reg;
  reg  [2:0]    hwPair_reg;
  reg  [2:0]    hwLast_reg;
  reg  [2:0]    hwIdx_reg;
  reg  [2:0]    state_reg;
  reg  [7:0]    cnt_reg;
  reg  [PW-1:0] ptr_reg;
  reg           stepIsEnd_reg;
  wire          stRise = stS2_reg & ~stPrev_reg;
  wire          seqOn  = regMode_reg ? swSeq_reg : hwSeq_reg;
  wire          burstOn = seqOn & (regMode_reg ? swBurst_reg : hwBurst_reg);
  wire          hwLastNow = (hwIdx_reg == hwLast_reg);

  acs_pulse_meter #(
    .CW(8)
  ) uMeter (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .pinRstN     (resetPinN),
    .partialPulse(partialPulse),
    .fullPulse   (fullPulse)
  );

  acs_step_mem uMem (
    .sys_clk(sys_clk),
    .wrEn   (stepWrite),
    .wrAddr (stepAddr),
    .wrData ({stepEnd, stepBSel, stepASel}),
    .rdAddr (ptr_reg),
    .rdData (stepRd)
  );

  // two stages on every pin input; only the second stage is read
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      codeS1_reg <= 3'h0;
      codeS2_reg <= 3'h0;
      stS1_reg   <= 1'b0;
      stS2_reg   <= 1'b0;
      stPrev_reg <= 1'b0;
      rdyS1_reg  <= 3'h0;
      rdyS2_reg  <= 3'h0;
    end else begin
      codeS1_reg <= channel_code_bus;
      codeS2_reg <= codeS1_reg;
      stS1_reg   <= conversion_start_strobe;
      stS2_reg   <= stS1_reg;
      stPrev_reg <= stS2_reg;
      rdyS1_reg  <= {regModePin, sequencerEnablePin, burstPin};
      rdyS2_reg  <= rdyS1_reg;
    end
  end

  // configuration: straps latched only on full reset release
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regMode_reg <= 1'b0;
      hwSeq_reg   <= 1'b0;
      hwBurst_reg <= 1'b0;
      swSeq_reg   <= 1'b0;
      swBurst_reg <= 1'b0;
      chanA_reg   <= 4'h0;
      chanB_reg   <= 4'h0;
    end else if (fullPulse) begin
      regMode_reg <= rdyS2_reg[2];
      hwSeq_reg   <= rdyS2_reg[1];
      hwBurst_reg <= rdyS2_reg[0];
      swSeq_reg   <= 1'b0;
      swBurst_reg <= 1'b0;
      chanA_reg   <= 4'h0;
      chanB_reg   <= 4'h0;
    end else if (cfgWrite) begin
      swSeq_reg   <= cfgSeqEnable;
      swBurst_reg <= cfgBurst;
      chanA_reg   <= cfgChanA;
      chanB_reg   <= cfgChanB;
    end
  end

  // conversion engine
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg       <= ST_IDLE;
      cnt_reg         <= 8'h00;
      ptr_reg         <= 5'h00;
      hwPair_reg      <= 3'h0;
      hwLast_reg      <= 3'h0;
      hwIdx_reg       <= 3'h0;
      stepIsEnd_reg   <= 1'b0;
      busy            <= 1'b0;
      convPulse       <= 1'b0;
      a_side_selector <= 4'h0;
      b_side_selector <= 4'h0;
    end else begin
      convPulse <= 1'b0;
      if (partialPulse || fullPulse) begin
        // ongoing result dropped; pointer rewound, step memory kept
        state_reg  <= ST_IDLE;
        busy       <= 1'b0;
        ptr_reg    <= 5'h00;
        hwIdx_reg  <= 3'h0;
        hwPair_reg <= codeS2_reg;
        hwLast_reg <= codeS2_reg;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (stRise) begin
              busy      <= 1'b1;
              state_reg <= ST_LOAD;
            end
          end
          ST_LOAD: begin
            // step memory read data valid here
            if (!regMode_reg) begin
              if (hwSeq_reg) begin
                a_side_selector <= {1'b0, hwIdx_reg};
                b_side_selector <= {1'b0, hwIdx_reg};
              end else begin
                a_side_selector <= {1'b0, hwPair_reg};
                b_side_selector <= {1'b0, hwPair_reg};
              end
            end else if (swSeq_reg) begin
              a_side_selector <= stepRd[`ACS_FLD_ASEL_LSB +: SW];
              b_side_selector <= stepRd[`ACS_FLD_BSEL_LSB +: SW];
            end else begin
              a_side_selector <= chanA_reg;
              b_side_selector <= chanB_reg;
            end
            stepIsEnd_reg <= stepRd[`ACS_FLD_END_BIT];
            cnt_reg       <= 8'h00;
            state_reg     <= ST_CONV;
          end
          ST_CONV: begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg == CONV_LAST) begin
              convPulse <= 1'b1;
              state_reg <= ST_DONE;
            end
          end
          ST_DONE: begin
            // code sampled while busy decides the next pair
            if (!hwSeq_reg) begin
              hwPair_reg <= codeS2_reg;
            end
            if (regMode_reg && swSeq_reg) begin
              // depth 1..32 set by the end marker
              if (stepIsEnd_reg || ptr_reg == 5'h1f) begin
                ptr_reg <= 5'h00;
              end else begin
                ptr_reg <= ptr_reg + 5'h01;
              end
            end
            if (!regMode_reg && hwSeq_reg) begin
              if (hwLastNow) begin
                hwIdx_reg  <= 3'h0;
                hwLast_reg <= codeS2_reg;
              end else begin
                hwIdx_reg <= hwIdx_reg + 3'h1;
              end
            end
            if (burstOn && !(regMode_reg ?
                (stepIsEnd_reg || ptr_reg == 5'h1f) : hwLastNow)) begin
              state_reg <= ST_NEXT;
            end else begin
              busy      <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
          ST_NEXT: begin
            // gives the step memory a cycle to read the new pointer
            state_reg <= ST_LOAD;
          end
          default: begin
            state_reg <= ST_IDLE;
            busy      <= 1'b0;
          end
        endcase
      end
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stepPointer   <= 5'h00;
      regModeActive <= 1'b0;
      seqActive     <= 1'b0;
    end else begin
      stepPointer   <= ptr_reg;
      regModeActive <= regMode_reg;
      seqActive     <= seqOn;
    end
  end
endmodule
`default_nettype wire

// *** testbench/acs_seq_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module acs_seq_sva #(
  parameter CONV_CYC = 20
) (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       resetPinN,
  input wire logic       conversion_start_strobe,
  input wire logic       busy,
  input wire logic [3:0] a_side_selector,
  input wire logic [3:0] b_side_selector,
  input wire logic       convPulse,
  input wire logic       regModeActive,
  input wire logic       seqActive
);
  localparam int CLO = CONV_CYC - 1;
  localparam int CHI = CONV_CYC + 3;
  logic [3:0] relAge_reg;
  // cycles since the reset pin was last seen low
  always @(posedge sys_clk or posedge sys_rst)
    if (sys_rst) relAge_reg <= 4'hf;
    else if (!resetPinN) relAge_reg <= 4'h0;
    else if (relAge_reg != 4'hf) relAge_reg <= relAge_reg + 4'h1;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    $rose(conversion_start_strobe) && !busy;
  endsequence
  sequence s_done;
    ##[CLO:CHI] convPulse;
  endsequence
  property p_startBusy; s_start |-> ##[1:5] busy; endproperty
  property p_convTime; $rose(busy) |-> s_done; endproperty
  property p_busyMin; $rose(busy) |-> busy[*8]; endproperty
  // a reset pulse on the pin may also end a conversion early
  property p_busyEnd;
    $fell(busy) |-> $past(convPulse) || relAge_reg < 4'h8;
  endproperty
  property p_pulse; convPulse |-> busy ##1 !convPulse; endproperty
  property p_selHold;
    convPulse |-> a_side_selector == $past(a_side_selector, 8)
      && b_side_selector == $past(b_side_selector, 8);
  endproperty
  property p_pinPair;
    convPulse && !regModeActive |-> a_side_selector == b_side_selector
      && !a_side_selector[3];
  endproperty
  property p_modeHold;
    $changed(regModeActive) || (!regModeActive && $changed(seqActive))
      |-> relAge_reg < 4'hc;
  endproperty
  a_startBusy: assert property (p_startBusy) else $error("busy late");
  a_convTime: assert property (p_convTime) else $error("no end");
  a_busyMin: assert property (p_busyMin) else $error("busy short");
  a_busyEnd: assert property (p_busyEnd) else $error("busy fell");
  a_pulse: assert property (p_pulse) else $error("bad pulse");
  a_selHold: assert property (p_selHold) else $error("sel moved");
  a_pinPair: assert property (p_pinPair) else $error("pair");
  a_modeHold: assert property (p_modeHold) else $error("mode");
endmodule
bind acs_sequencer acs_seq_sva #(.CONV_CYC(CONV_CYC)) u_sva (.sys_clk,
  .sys_rst, .resetPinN, .conversion_start_strobe, .busy, .a_side_selector,
  .b_side_selector, .convPulse, .regModeActive, .seqActive);
`default_nettype wire

// *** testbench/acs_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module acs_host_model (
  input  wire logic       sys_clk,
  input  wire logic       busy,
  input  wire logic       convPulse,
  input  wire logic [3:0] a_side_selector,
  input  wire logic [3:0] b_side_selector,
  output var  logic       resetPinN,
  output var  logic       conversion_start_strobe,
  output var  logic [2:0] channel_code_bus
);
  initial begin
    {resetPinN, conversion_start_strobe, channel_code_bus} = 5'h10;
  end
  task automatic pinReset(input int lowCyc, input logic [2:0] c);
    @(posedge sys_clk);
    #1 resetPinN = 1'b0;
    channel_code_bus = c;
    repeat (lowCyc) @(posedge sys_clk);
    #1 resetPinN = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  task automatic convert(input logic [2:0] c, output int pulses,
                         output logic [3:0] a, output logic [3:0] b);
    int n;
    {pulses, n} = '0;
    // unknown until a pulse is seen, so a silent device cannot pass
    {a, b} = 'x;
    @(posedge sys_clk);
    #1 channel_code_bus = c;
    @(posedge sys_clk);
    #1 conversion_start_strobe = 1'b1;
    while (busy !== 1'b1 && n < 10) begin
      @(posedge sys_clk);
      #1 n++;
    end
    conversion_start_strobe = 1'b0;
    while (busy === 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      #1 n++;
      if (convPulse === 1'b1) begin
        if (pulses == 0) {a, b} = {a_side_selector, b_side_selector};
        pulses++;
      end
    end
    // code is read only while busy or at reset release, so scramble it
    channel_code_bus = ~c;
  endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic       sys_clk, sys_rst, resetPinN, regModePin, sequencerEnablePin;
  logic       burstPin, conversion_start_strobe, cfgWrite, cfgSeqEnable;
  logic       cfgBurst, stepWrite, stepEnd, busy, convPulse;
  logic       regModeActive, seqActive;
  logic [2:0] channel_code_bus, prev, nxt;
  logic [3:0] cfgChanA, cfgChanB, stepASel, stepBSel, gotA, gotB;
  logic [3:0] a_side_selector, b_side_selector;
  logic [4:0] stepAddr, stepPointer;
  logic [3:0] expA [32];
  logic [3:0] expB [32];
  int         mismatches, check_count, pulses, k, d;
  acs_host_model host (.sys_clk, .busy, .convPulse, .a_side_selector,
    .b_side_selector, .resetPinN, .conversion_start_strobe,
    .channel_code_bus);
  acs_sequencer DUT (.sys_clk, .sys_rst, .resetPinN, .regModePin,
    .sequencerEnablePin, .burstPin, .channel_code_bus,
    .conversion_start_strobe, .cfgWrite, .cfgSeqEnable, .cfgBurst,
    .cfgChanA, .cfgChanB, .stepWrite, .stepAddr, .stepASel, .stepBSel,
    .stepEnd, .busy, .a_side_selector, .b_side_selector, .convPulse,
    .stepPointer, .regModeActive, .seqActive);
  function automatic logic [7:0] pinStep(int i, int kk);
    return 8'(i % (kk + 1));
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0h got %0h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fullRst(input logic rm, se, bu, input logic [2:0] c);
    {regModePin, sequencerEnablePin, burstPin} = {rm, se, bu};
    host.pinReset(125, c);
  endtask
  task automatic conv(input logic [2:0] c);
    host.convert(c, pulses, gotA, gotB);
  endtask
  task automatic wrCfg(input logic se, bu, input logic [3:0] a, b);
    {cfgSeqEnable, cfgBurst, cfgChanA, cfgChanB, cfgWrite} = {se, bu, a, b, 1'b1};
    @(posedge sys_clk);
    #1 cfgWrite = 1'b0;
  endtask
  task automatic loadSteps(input int dd);
    for (int i = 0; i < 32; i++) begin
      expA[i] = 4'($urandom);
      expB[i] = 4'($urandom);
      {stepAddr, stepASel, stepBSel, stepEnd} =
        {5'(i), expA[i], expB[i], i == dd - 1};
      stepWrite = 1'b1;
      @(posedge sys_clk);
      #1;
    end
    stepWrite = 1'b0;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #500_000;
    mismatches++;
    wrap_up;
  end
  initial begin
    {sys_rst, regModePin, sequencerEnablePin, burstPin} = 4'h8;
    {cfgWrite, cfgSeqEnable, cfgBurst, cfgChanA, cfgChanB} = 11'h000;
    {stepWrite, stepAddr, stepASel, stepBSel, stepEnd} = 15'h0000;
    {mismatches, check_count} = '0;
    void'($urandom(15));
    repeat (3) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    prev = 3'h5;
    fullRst(0, 0, 0, prev);
    chk("regMode", 0, regModeActive);
    for (int i = 0; i < 10; i++) begin
      nxt = (i < 8) ? 3'(i) : 3'($urandom);
      conv(nxt);
      chk("pinA", {1'b0, prev}, gotA);
      chk("pinB", {1'b0, prev}, gotB);
      prev = nxt;
    end
    k = 2 + $urandom % 6;
    fullRst(0, 1, 0, 3'(k));
    chk("seqAct", 1, seqActive);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < k + 2; i++) begin
        conv(3'(k));
        chk("seqA", pinStep(i, k), gotA);
        chk("seqB", pinStep(i, k), gotB);
      end
      sequencerEnablePin = 1'b0;
      host.pinReset(10, 3'(k));
      chk("seqKeep", 1, seqActive);
    end
    d = $urandom % 8;
    for (int i = 0; i < k + d + 2; i++) begin
      conv((i < k) ? ~3'(k) : 3'(d));
      chk("seqNew", (i <= k) ? i : i - k - 1, gotA);
    end
    for (int j = 0; j < 8; j += 7) begin
      fullRst(0, 1, 1, 3'(j));
      conv(3'(j));
      chk("burstCnt", j + 1, pulses);
      chk("burstA", 0, gotA);
    end
    fullRst(1, 0, 0, 3'($urandom));
    chk("regAct", 1, regModeActive);
    conv(3'h7);
    chk("dfltA", 0, gotA);
    chk("dfltB", 0, gotB);
    expA[0] = 4'($urandom);
    expB[0] = 4'($urandom);
    wrCfg(0, 0, expA[0], expB[0]);
    conv(3'h0);
    chk("regA", expA[0], gotA);
    chk("regB", expB[0], gotB);
    for (int j = 0; j < 3; j++) begin
      d = (j == 0) ? 1 : (j == 1) ? 32 : 2 + $urandom % 6;
      loadSteps(d);
      wrCfg(1, 0, 4'h0, 4'h0);
      host.pinReset(10, 3'h0);
      for (int i = 0; i <= d; i++) begin
        conv(3'($urandom));
        chk("stepA", expA[i % d], gotA);
        chk("stepB", expB[i % d], gotB);
      end
      @(posedge sys_clk);
      #1 chk("ptr", (d + 1) % d, stepPointer);
      wrCfg(1, 1, 4'h0, 4'h0);
      host.pinReset(10, 3'h0);
      chk("ptrRew", 0, stepPointer);
      conv(3'h0);
      chk("regBurst", d, pulses);
      chk("regBurstA", expA[0], gotA);
      wrCfg(0, 0, 4'h0, 4'h0);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
